// *** pkg/sgp_pkg.sv ***
// Overview of operation
// - Mode register selects code-to-gain mapping.
// - White balance two modes, exposure three.
// - Piecewise codes 0-32 step 0.02174.
// - Piecewise codes 33-63 step 0.0434.
// - Uniform-step codes 0-47 step 0.0434.
// - Extended uniform-step exposure only, codes 0-63.
// - Four tile gain registers at 00h-03h.
// - Tile registers map green, red, blue, green.
// - Exposure gain registers at 10h and 21h.
// - Global offset is 6-bit signed magnitude.
// - References programmable in 5 mV steps.
// - Reference defaults 1.9 V and 0.6 V.
// - High init input reinitializes, low runs.
// - Init restores defaults, clears counters, latches.
// - Power register bit 0 selects standby.
// - Tristate register floats sync and data outputs.
package sgp_pkg;

  localparam logic [6:0] SGP_DEV_ADDR       = 7'h3C;
  localparam logic [7:0] SGP_OFF_TILE_GA    = 8'h00;
  localparam logic [7:0] SGP_OFF_TILE_RED   = 8'h01;
  localparam logic [7:0] SGP_OFF_TILE_BLUE  = 8'h02;
  localparam logic [7:0] SGP_OFF_TILE_GB    = 8'h03;
  localparam logic [7:0] SGP_OFF_EXP_FIRST  = 8'h10;
  localparam logic [7:0] SGP_OFF_EXP_SECOND = 8'h21;
  localparam logic [7:0] SGP_OFF_POWER      = 8'h40;
  localparam logic [7:0] SGP_OFF_TRISTATE   = 8'h41;
  localparam logic [7:0] SGP_OFF_POS_REF    = 8'h42;
  localparam logic [7:0] SGP_OFF_NEG_REF    = 8'h43;
  localparam logic [7:0] SGP_OFF_GAIN_MODE  = 8'h44;
  localparam logic [7:0] SGP_OFF_OFFSET     = 8'h45;

  localparam int SGP_MODE_WB_BIT  = 0;
  localparam int SGP_MODE_EXP_LSB = 1;
  localparam int SGP_POWER_STBY   = 0;
  localparam int SGP_OFFSET_SIGN  = 5;

  localparam logic [5:0] SGP_GAIN_CODE_RST = 6'h00;
  localparam logic [2:0] SGP_MODE_RST      = 3'h0;
  localparam logic [5:0] SGP_OFFSET_RST    = 6'h00;
  localparam logic [5:0] SGP_HIZ_RST       = 6'h00;
  localparam logic [7:0] SGP_REF_STEPS     = 8'hFA;
  localparam logic [7:0] SGP_POS_REF_RST   = 8'h78;
  localparam logic [7:0] SGP_NEG_REF_RST   = 8'h78;
  localparam logic [2:0] SGP_PIN_IDLE      = 3'h3;

  localparam logic [18:0] SGP_GAIN_BASE   = 19'h10FB8;
  localparam logic [18:0] SGP_GAIN_FINE   = 19'h0087E;
  localparam logic [18:0] SGP_GAIN_KNEE   = 19'h21F5C;
  localparam logic [18:0] SGP_GAIN_COARSE = 19'h010F4;
  localparam logic [6:0]  SGP_KNEE_CODE   = 7'h20;
  localparam logic [6:0]  SGP_MAX_PIECE   = 7'h3F;
  localparam logic [6:0]  SGP_MAX_UNIFORM = 7'h2F;
  localparam logic [6:0]  SGP_MAX_EXT     = 7'h43;

  typedef enum logic [1:0] {
    SGP_MODE_PIECE   = 2'h0,
    SGP_MODE_UNIFORM = 2'h1,
    SGP_MODE_EXT     = 2'h2
  } sgp_gain_mode_e;

  typedef enum logic [8:0] {
    SGP_ST_IDLE    = 9'h001,
    SGP_ST_DEVADDR = 9'h002,
    SGP_ST_ACK_DEV = 9'h004,
    SGP_ST_REGADDR = 9'h008,
    SGP_ST_ACK_REG = 9'h010,
    SGP_ST_WDATA   = 9'h020,
    SGP_ST_ACK_W   = 9'h040,
    SGP_ST_RDATA   = 9'h080,
    SGP_ST_RACK    = 9'h100
  } sgp_state_e;

endpackage

// *** core/sgp_gain_dec.sv ***
module sgp_gain_dec
  import sgp_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire sgp_gain_mode_e i_mode,
  input  wire logic [5:0]     i_code,
  output logic      [18:0]    o_gain
);

  logic [6:0]  code_c;
  logic [18:0] gain_nxt;

  // Clamp the code to the top of the selected mode's range.
  always_comb begin
    code_c = {1'b0, i_code};
    case (i_mode)
      SGP_MODE_UNIFORM: begin
        if (code_c > SGP_MAX_UNIFORM) begin
          code_c = SGP_MAX_UNIFORM;
        end
      end
      SGP_MODE_EXT: begin
        if (code_c > SGP_MAX_EXT) begin
          code_c = SGP_MAX_EXT;
        end
      end
      default: begin
        if (code_c > SGP_MAX_PIECE) begin
          code_c = SGP_MAX_PIECE;
        end
      end
    endcase
  end

  // Gain is held in units of 1e-5.
  always_comb begin
    if (i_mode == SGP_MODE_PIECE) begin
      if (code_c <= SGP_KNEE_CODE) begin
        gain_nxt = SGP_GAIN_BASE + 19'(code_c) * SGP_GAIN_FINE;
      end else begin
        gain_nxt = SGP_GAIN_KNEE
                 + 19'(code_c - SGP_KNEE_CODE) * SGP_GAIN_COARSE;
      end
    end else begin
      gain_nxt = SGP_GAIN_BASE + 19'(code_c) * SGP_GAIN_COARSE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_gain <= SGP_GAIN_BASE;
    end else begin
      o_gain <= gain_nxt;
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);

  uniform_clamp_a: assert property (
    ($past(i_mode) == SGP_MODE_UNIFORM && $past(i_code) >= 6'h2F)
      |-> o_gain == SGP_GAIN_BASE + 19'(SGP_MAX_UNIFORM) * SGP_GAIN_COARSE)
    else $error("Uniform gain code not clamped.");

  piece_knee_a: assert property (
    ($past(i_mode) == SGP_MODE_PIECE && $past(i_code) == 6'h20)
      |-> o_gain == SGP_GAIN_BASE + 19'h10FC0)
    else $error("Piecewise gain at the knee code is wrong.");

endmodule

// *** core/sgp_ctrl.sv ***
module sgp_ctrl
  import sgp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_init,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe_n,
  output logic      [18:0] o_tile_green_a_gain,
  output logic      [18:0] o_tile_red_gain,
  output logic      [18:0] o_tile_blue_gain,
  output logic      [18:0] o_tile_green_b_gain,
  output logic      [18:0] o_exposure_gain_first,
  output logic      [18:0] o_exposure_gain_second,
  output logic             o_offset_sign,
  output logic      [4:0]  o_offset_mag,
  output logic      [7:0]  o_pos_ref_code,
  output logic      [7:0]  o_neg_ref_code,
  output logic             o_standby,
  output logic      [5:0]  o_hiz_sel,
  output logic             o_init_active
);

  logic [2:0]     sync1_r;
  logic [2:0]     sync2_r;
  logic [2:0]     sync3_r;
  logic [2:0]     pin_r;
  logic [2:0]     prev_r;
  logic           rst_all;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  sgp_state_e     state_r;
  logic [3:0]     bit_cnt_r;
  logic [7:0]     shift_r;
  logic [7:0]     ptr_r;
  logic           rd_r;
  logic           byte_end;
  logic           wr_go;
  logic [7:0]     rd_data;
  logic [5:0]     code_r [6];
  logic [2:0]     mode_r;
  logic [5:0]     offset_r;
  sgp_gain_mode_e wb_mode;
  sgp_gain_mode_e exp_mode;
  logic [18:0]    gain_w [6];

  // Pins pass three flops; a change is taken once the last two agree.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= SGP_PIN_IDLE;
      sync2_r <= SGP_PIN_IDLE;
      sync3_r <= SGP_PIN_IDLE;
      pin_r   <= SGP_PIN_IDLE;
      prev_r  <= SGP_PIN_IDLE;
    end else begin
      sync1_r <= {i_init, i_sda, i_scl};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r   <= (sync3_r & ~(sync2_r ^ sync3_r))
               | (pin_r & (sync2_r ^ sync3_r));
      prev_r  <= pin_r;
    end
  end

  // A high init level holds every register after the pin synchronizer at its default.
  assign rst_all   = i_rst | pin_r[2];
  assign scl_rise  = pin_r[0] & ~prev_r[0];
  assign scl_fall  = ~pin_r[0] & prev_r[0];
  assign start_det = pin_r[0] & prev_r[0] & prev_r[1] & ~pin_r[1];
  assign stop_det  = pin_r[0] & prev_r[0] & ~prev_r[1] & pin_r[1];
  assign byte_end  = scl_fall && (bit_cnt_r == 4'h8);
  assign wr_go     = (state_r == SGP_ST_WDATA) && byte_end;

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_init_active <= 1'b1;
    end else begin
      o_init_active <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      state_r    <= SGP_ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      ptr_r      <= 8'h00;
      rd_r       <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state_r    <= SGP_ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state_r    <= SGP_ST_DEVADDR;
      bit_cnt_r  <= 4'h0;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state_r)
        SGP_ST_DEVADDR, SGP_ST_REGADDR, SGP_ST_WDATA: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], pin_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            bit_cnt_r <= 4'h0;
            if (state_r == SGP_ST_DEVADDR) begin
              if (shift_r[7:1] == SGP_DEV_ADDR) begin
                rd_r       <= shift_r[0];
                o_sda_oe_n <= 1'b0;
                state_r    <= SGP_ST_ACK_DEV;
              end else begin
                state_r <= SGP_ST_IDLE;
              end
            end else if (state_r == SGP_ST_REGADDR) begin
              ptr_r      <= shift_r;
              o_sda_oe_n <= 1'b0;
              state_r    <= SGP_ST_ACK_REG;
            end else begin
              ptr_r      <= ptr_r + 8'h01;
              o_sda_oe_n <= 1'b0;
              state_r    <= SGP_ST_ACK_W;
            end
          end
        end
        SGP_ST_ACK_DEV: begin
          if (scl_fall) begin
            if (rd_r) begin
              shift_r    <= {rd_data[6:0], 1'b0};
              o_sda_oe_n <= rd_data[7];
              bit_cnt_r  <= 4'h0;
              state_r    <= SGP_ST_RDATA;
            end else begin
              o_sda_oe_n <= 1'b1;
              state_r    <= SGP_ST_REGADDR;
            end
          end
        end
        SGP_ST_ACK_REG, SGP_ST_ACK_W: begin
          if (scl_fall) begin
            o_sda_oe_n <= 1'b1;
            state_r    <= SGP_ST_WDATA;
          end
        end
        SGP_ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            o_sda_oe_n <= 1'b1;
            ptr_r      <= ptr_r + 8'h01;
            state_r    <= SGP_ST_RACK;
          end else if (scl_fall) begin
            o_sda_oe_n <= shift_r[7];
            shift_r    <= {shift_r[6:0], 1'b0};
          end
        end
        SGP_ST_RACK: begin
          if (scl_rise && pin_r[1]) begin
            state_r <= SGP_ST_IDLE;
          end else if (scl_fall) begin
            shift_r    <= {rd_data[6:0], 1'b0};
            o_sda_oe_n <= rd_data[7];
            bit_cnt_r  <= 4'h0;
            state_r    <= SGP_ST_RDATA;
          end
        end
        default: begin
          o_sda_oe_n <= 1'b1;
          state_r    <= SGP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    o_sda_o <= 1'b0;
  end

  // Gain code registers: four tile entries then two exposure entries.
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      for (int i = 0; i < 6; i++) begin
        code_r[i] <= SGP_GAIN_CODE_RST;
      end
    end else if (wr_go) begin
      case (ptr_r)
        SGP_OFF_TILE_GA:    code_r[0] <= shift_r[5:0];
        SGP_OFF_TILE_RED:   code_r[1] <= shift_r[5:0];
        SGP_OFF_TILE_BLUE:  code_r[2] <= shift_r[5:0];
        SGP_OFF_TILE_GB:    code_r[3] <= shift_r[5:0];
        SGP_OFF_EXP_FIRST:  code_r[4] <= shift_r[5:0];
        SGP_OFF_EXP_SECOND: code_r[5] <= shift_r[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      mode_r         <= SGP_MODE_RST;
      offset_r       <= SGP_OFFSET_RST;
      o_offset_sign  <= 1'b0;
      o_offset_mag   <= 5'h00;
      o_pos_ref_code <= SGP_POS_REF_RST;
      o_neg_ref_code <= SGP_NEG_REF_RST;
      o_standby      <= 1'b0;
      o_hiz_sel      <= SGP_HIZ_RST;
    end else begin
      o_offset_sign <= offset_r[SGP_OFFSET_SIGN];
      o_offset_mag  <= offset_r[4:0];
      if (wr_go) begin
        case (ptr_r)
          SGP_OFF_GAIN_MODE: mode_r <= shift_r[2:0];
          SGP_OFF_OFFSET:    offset_r <= shift_r[5:0];
          SGP_OFF_POWER:     o_standby <= shift_r[SGP_POWER_STBY];
          SGP_OFF_TRISTATE:  o_hiz_sel <= shift_r[5:0];
          SGP_OFF_POS_REF: begin
            o_pos_ref_code <= (shift_r > SGP_REF_STEPS) ? SGP_REF_STEPS
                                                       : shift_r;
          end
          SGP_OFF_NEG_REF: begin
            o_neg_ref_code <= (shift_r > SGP_REF_STEPS) ? SGP_REF_STEPS
                                                       : shift_r;
          end
          default: ;
        endcase
      end
    end
  end

  // White balance has two modes; exposure a third, extended one.
  always_comb begin
    wb_mode = mode_r[SGP_MODE_WB_BIT] ? SGP_MODE_UNIFORM
                                      : SGP_MODE_PIECE;
    case (mode_r[SGP_MODE_EXP_LSB +: 2])
      2'h1:    exp_mode = SGP_MODE_UNIFORM;
      2'h2:    exp_mode = SGP_MODE_EXT;
      default: exp_mode = SGP_MODE_PIECE;
    endcase
  end

  always_comb begin
    case (ptr_r)
      SGP_OFF_TILE_GA:    rd_data = {2'h0, code_r[0]};
      SGP_OFF_TILE_RED:   rd_data = {2'h0, code_r[1]};
      SGP_OFF_TILE_BLUE:  rd_data = {2'h0, code_r[2]};
      SGP_OFF_TILE_GB:    rd_data = {2'h0, code_r[3]};
      SGP_OFF_EXP_FIRST:  rd_data = {2'h0, code_r[4]};
      SGP_OFF_EXP_SECOND: rd_data = {2'h0, code_r[5]};
      SGP_OFF_GAIN_MODE:  rd_data = {5'h00, mode_r};
      SGP_OFF_OFFSET:     rd_data = {2'h0, offset_r};
      SGP_OFF_POWER:      rd_data = {7'h00, o_standby};
      SGP_OFF_TRISTATE:   rd_data = {2'h0, o_hiz_sel};
      SGP_OFF_POS_REF:    rd_data = o_pos_ref_code;
      SGP_OFF_NEG_REF:    rd_data = o_neg_ref_code;
      default:            rd_data = 8'h00;
    endcase
  end

  for (genvar g = 0; g < 6; g++) begin : g_dec
    sgp_gain_dec u_dec (
      .i_clk  (i_clk),
      .i_rst  (rst_all),
      .i_mode ((g < 4) ? wb_mode : exp_mode),
      .i_code (code_r[g]),
      .o_gain (gain_w[g])
    );
  end

  assign o_tile_green_a_gain    = gain_w[0];
  assign o_tile_red_gain        = gain_w[1];
  assign o_tile_blue_gain       = gain_w[2];
  assign o_tile_green_b_gain    = gain_w[3];
  assign o_exposure_gain_first  = gain_w[4];
  assign o_exposure_gain_second = gain_w[5];

  default clocking cc @(posedge i_clk); endclocking
  default disable iff (i_rst);

  init_defaults_a: assert property (
    pin_r[2] |=> o_pos_ref_code == 8'h78 && o_neg_ref_code == 8'h78
                 && o_standby == 1'b0 && o_init_active)
    else $error("Defaults not restored under init.");

  init_gain_a: assert property (
    pin_r[2] [*2] |=> o_exposure_gain_first == SGP_GAIN_BASE
                      && o_tile_red_gain == SGP_GAIN_BASE)
    else $error("Gain outputs not at default after init.");

  standby_write_a: assert property (
    (wr_go && ptr_r == SGP_OFF_POWER) |=> o_standby == $past(shift_r[0]))
    else $error("Standby bit did not follow the power write.");

  hiz_write_a: assert property (
    (wr_go && ptr_r == SGP_OFF_TRISTATE) |=> o_hiz_sel == $past(shift_r[5:0]))
    else $error("Tristate selection did not follow the write.");

  ref_range_a: assert property (
    o_pos_ref_code <= 8'hFA && o_neg_ref_code <= 8'hFA)
    else $error("Reference code beyond its range.");

  red_gain_path_a: assert property (
    (wr_go && ptr_r == SGP_OFF_TILE_RED && shift_r[5:0] == 6'h00 && !pin_r[2])
      ##1 !pin_r[2] |=> o_tile_red_gain == SGP_GAIN_BASE)
    else $error("Red tile gain did not follow its code.");

  exp_ext_a: assert property (
    (exp_mode == SGP_MODE_EXT && code_r[4] == 6'h3F) ##1 $stable(code_r[4])
      && exp_mode == SGP_MODE_EXT
      |=> o_exposure_gain_first == SGP_GAIN_BASE + 19'h42C0C)
    else $error("Extended exposure gain is wrong.");

  offset_path_a: assert property (
    (wr_go && ptr_r == SGP_OFF_OFFSET) ##1 !pin_r[2]
      |=> {o_offset_sign, o_offset_mag} == $past(shift_r[5:0], 2))
    else $error("Offset code did not reach the outputs.");

  ack_drive_a: assert property (
    (state_r == SGP_ST_ACK_DEV) |-> !o_sda_oe_n)
    else $error("Address acknowledge not driven.");

  wb_mode_a: assert property (
    wb_mode != SGP_MODE_EXT)
    else $error("White balance took the extended mode.");

  write_seen_c: cover property (wr_go && ptr_r == SGP_OFF_TILE_GA);
  read_seen_c: cover property (state_r == SGP_ST_RDATA && scl_fall);
  init_seen_c: cover property ($fell(pin_r[2]));
  ext_mode_c: cover property (exp_mode == SGP_MODE_EXT);

endmodule

// *** tb/sgp_host_model.sv ***
module sgp_host_model #(
  parameter int HALF     = 4,
  parameter int INIT_CYC = 40000
) (
  input  wire logic       i_clk,
  input  wire logic       i_dev_oe_n,
  input  wire logic       i_dev_o,
  output logic            o_scl,
  output wire             o_sda,
  output logic            o_init,
  output logic            o_res_valid,
  output logic      [7:0] o_res_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull_low;
  // The pull-up holds the wire high unless either side pulls it low.
  assign o_sda = !(pull_low || (!i_dev_oe_n && !i_dev_o));
  initial begin
    o_scl = 1'b1;
    pull_low = 1'b0;
    o_init = 1'b0;
    o_res_valid = 1'b0;
    o_res_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // The low phase outlasts the device's input delay, so its drive settles
  // before the clock rises again.
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    pull_low = !b;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    r = o_sda;
    o_scl = 1'b0;
  endtask
  task automatic start();
    tick(HALF);
    pull_low = 1'b1;
    tick(HALF);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    tick(HALF / 2);
    pull_low = 1'b1;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    pull_low = 1'b0;
    tick(HALF);
  endtask
  // Posts one result per byte: the read data, or the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | d[i], r);
      v = {v[6:0], r};
    end
    bit_io(rd ? last : 1'b1, r);
    o_res_data = rd ? v : {7'h00, r};
    o_res_valid = 1'b1;
    tick(1);
    o_res_valid = 1'b0;
  endtask
  // Holds the init pin high, then waits before any further traffic.
  task automatic do_init();
    o_init = 1'b1;
    tick(INIT_CYC);
    o_init = 1'b0;
    tick(INIT_CYC);
  endtask
endmodule

// *** tb/tb.sv ***
module tb
  import sgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  wire         scl, sda, init_pin, res_valid;
  wire  [7:0]  res_data;
  logic        sda_o, sda_oe_n, off_sign, stby, init_act;
  logic [4:0]  off_mag;
  logic [7:0]  pos_ref, neg_ref, pos_s, neg_s;
  logic [5:0]  hiz, off_s, hiz_s;
  logic [18:0] g [6];
  logic [5:0]  code_s [6];
  logic [2:0]  mode_s;
  logic        stby_s;
  logic [7:0]  exp_q [$];
  int          miscompares, check_count;
  logic [5:0]  bnd [8] = '{6'h00, 6'h20, 6'h21, 6'h2F, 6'h30, 6'h3F, 6'h01,
                          6'h1F};
  always #12.5 i_clk = ~i_clk;
  sgp_ctrl i_sgp_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_init(init_pin),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
    .o_tile_green_a_gain(g[0]), .o_tile_red_gain(g[1]),
    .o_tile_blue_gain(g[2]), .o_tile_green_b_gain(g[3]),
    .o_exposure_gain_first(g[4]), .o_exposure_gain_second(g[5]),
    .o_offset_sign(off_sign), .o_offset_mag(off_mag),
    .o_pos_ref_code(pos_ref), .o_neg_ref_code(neg_ref), .o_standby(stby),
    .o_hiz_sel(hiz), .o_init_active(init_act));
  sgp_host_model i_sgp_host_model (.i_clk(i_clk), .i_dev_oe_n(sda_oe_n),
    .i_dev_o(sda_o), .o_scl(scl), .o_sda(sda), .o_init(init_pin),
    .o_res_valid(res_valid), .o_res_data(res_data));
  task automatic summarize();
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_port(input logic [18:0] got, input logic [18:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge i_clk) begin
    if (res_valid === 1'b1)
      cmp_byte(res_data, exp_q.pop_front());
  end
  function automatic logic [18:0] gain_of(logic [1:0] m, logic [5:0] c);
    int k;
    k = (m == 2'h1 && c > 6'h2F) ? 47 : int'(c);
    if (m == 2'h0)
      return (c <= 6'h20) ? 19'(69560 + 2174 * k) : 19'(139100 + 4340 * (k - 32));
    return 19'(69560 + 4340 * k);
  endfunction
  function automatic logic [7:0] rd_exp(logic [7:0] a);
    case (a)
      8'h00, 8'h01, 8'h02, 8'h03: return {2'h0, code_s[a[1:0]]};
      SGP_OFF_EXP_FIRST:  return {2'h0, code_s[4]};
      SGP_OFF_EXP_SECOND: return {2'h0, code_s[5]};
      SGP_OFF_POWER:      return {7'h00, stby_s};
      SGP_OFF_TRISTATE:   return {2'h0, hiz_s};
      SGP_OFF_POS_REF:    return pos_s;
      SGP_OFF_NEG_REF:    return neg_s;
      SGP_OFF_GAIN_MODE:  return {5'h00, mode_s};
      SGP_OFF_OFFSET:     return {2'h0, off_s};
      default:            return 8'h00;
    endcase
  endfunction
  task automatic apply(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h00, 8'h01, 8'h02, 8'h03: code_s[a[1:0]] = d[5:0];
      SGP_OFF_EXP_FIRST:  code_s[4] = d[5:0];
      SGP_OFF_EXP_SECOND: code_s[5] = d[5:0];
      SGP_OFF_POWER:      stby_s = d[0];
      SGP_OFF_TRISTATE:   hiz_s = d[5:0];
      SGP_OFF_POS_REF:    pos_s = (d > 8'hFA) ? 8'hFA : d;
      SGP_OFF_NEG_REF:    neg_s = (d > 8'hFA) ? 8'hFA : d;
      SGP_OFF_GAIN_MODE:  mode_s = d[2:0];
      SGP_OFF_OFFSET:     off_s = d[5:0];
      default: ;
    endcase
  endtask
  task automatic set_defaults();
    foreach (code_s[i]) code_s[i] = 6'h00;
    {mode_s, off_s, hiz_s, stby_s} = 16'h0000;
    pos_s = 8'h78;
    neg_s = 8'h78;
  endtask
  task automatic put(input logic [7:0] b, input logic r, input logic l,
                     input logic [7:0] e);
    exp_q.push_back(e);
    i_sgp_host_model.xfer(b, r, l);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d [4], input int n);
    i_sgp_host_model.start();
    put({SGP_DEV_ADDR, 1'b0}, 1'b0, 1'b0, 8'h00);
    put(p, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < n; i++) begin
      put(d[i], 1'b0, 1'b0, 8'h00);
      apply(p + 8'(i), d[i]);
    end
    i_sgp_host_model.stop();
  endtask
  task automatic one(input logic [7:0] p, input logic [7:0] v);
    wr(p, '{v, 8'h00, 8'h00, 8'h00}, 1);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    i_sgp_host_model.start();
    put({SGP_DEV_ADDR, 1'b0}, 1'b0, 1'b0, 8'h00);
    put(p, 1'b0, 1'b0, 8'h00);
    i_sgp_host_model.stop();
    i_sgp_host_model.start();
    put({SGP_DEV_ADDR, 1'b1}, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < n; i++)
      put(8'hFF, 1'b1, i == n - 1, rd_exp(p + 8'(i)));
    i_sgp_host_model.stop();
  endtask
  task automatic chk_all();
    logic [1:0] em;
    em = (mode_s[2:1] == 2'h3) ? 2'h0 : mode_s[2:1];
    repeat (8) @(posedge i_clk);
    #1;
    for (int i = 0; i < 4; i++)
      cmp_port(g[i], gain_of({1'b0, mode_s[0]}, code_s[i]));
    for (int i = 4; i < 6; i++)
      cmp_port(g[i], gain_of(em, code_s[i]));
    cmp_port(19'(pos_ref), 19'(pos_s));
    cmp_port(19'(neg_ref), 19'(neg_s));
    cmp_port(19'({off_sign, off_mag}), 19'(off_s));
    cmp_port(19'(stby), 19'(stby_s));
    cmp_port(19'(hiz), 19'(hiz_s));
  endtask
  initial begin
    repeat (150000) @(posedge i_clk);
    miscompares++;
    summarize();
  end
  initial begin
    miscompares = 0;
    check_count = 0;
    void'($urandom(51));
    set_defaults();
    repeat (4) @(posedge i_clk);
    #1 i_rst = 1'b0;
    chk_all();
    cmp_port(19'(init_act), 19'h0);
    rd(8'h00, 4);
    for (int k = 0; k < 8; k++) begin
      one(SGP_OFF_GAIN_MODE, 8'(k));
      wr(8'h00, '{8'(bnd[k]), 8'($urandom_range(255)),
                  8'($urandom_range(255)), 8'(bnd[7 - k])}, 4);
      one(SGP_OFF_EXP_FIRST, 8'(bnd[k]));
      one(SGP_OFF_EXP_SECOND, 8'($urandom_range(255)));
      chk_all();
      rd(8'h00, 4);
    end
    one(SGP_OFF_TILE_RED, 8'hC0);
    wr(SGP_OFF_POWER, '{8'h01, 8'hEA, 8'hFF, 8'h00}, 4);
    one(SGP_OFF_OFFSET, 8'hE5);
    chk_all();
    rd(SGP_OFF_POWER, 6);
    one(SGP_OFF_POS_REF, 8'hFA);
    one(SGP_OFF_NEG_REF, 8'hFB);
    one(SGP_OFF_POWER, 8'h00);
    chk_all();
    one(8'h50, 8'hAA);
    rd(8'h50, 1);
    i_sgp_host_model.start();
    put({SGP_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, 1'b0, 8'h01);
    i_sgp_host_model.stop();
    rd(SGP_OFF_NEG_REF, 1);
    fork
      i_sgp_host_model.do_init();
      begin
        repeat (100) @(posedge i_clk);
        #1;
        cmp_port(19'(init_act), 19'h1);
      end
    join
    set_defaults();
    chk_all();
    cmp_port(19'(init_act), 19'h0);
    rd(SGP_OFF_POS_REF, 2);
    summarize();
  end
endmodule
